// *** src/dfrs_pkg.sv ***
package dfrs_pkg;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_TIME_NS = 10_000_000;   // 10 ms sequencer and filter step
    localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 17;

    // ****************************************************************
    // widths and limits
    // ****************************************************************
    localparam int FREQ_W = 14;                 // 0.01 Hz units
    localparam int JUMP_W = 7;                  // 1 Hz units
    localparam int BAND_W = 5;                  // 1 Hz units, 0 to 31
    localparam int TIME_W = 20;                 // stage time in 10 ms units
    localparam int TAU_W = 9;                   // filter time in 10 ms units
    localparam int ADC_W = 12;
    localparam int JUMPS = 3;
    localparam int STAGES = 7;
    localparam logic [13:0] FREQ_MAX = 14'h2EE0;    // 120.00 Hz
    localparam logic [13:0] HZ_TO_CENT = 14'h0064;  // 1 Hz in 0.01 Hz units
    localparam logic [6:0] JUMP_MAX = 7'h78;        // 120 Hz
    localparam logic [11:0] ADC_FULL = 12'hFFF;

    // ****************************************************************
    // sequencer encodings and reset values
    // ****************************************************************
    localparam logic [2:0] STAGE_FIRST = 3'h0;
    localparam logic [2:0] STAGE_LAST = 3'h6;
    localparam logic [1:0] MODE_ONCE = 2'h0;
    localparam logic [1:0] MODE_REPEAT = 2'h1;
    localparam logic [1:0] MODE_HOLD_LAST = 2'h2;
    localparam logic [1:0] RAMP_SET_1 = 2'h0;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_HOLD} dfrs_seq_t;
endpackage

// *** src/dfrs_jump_band.sv ***
`timescale 1ns/1ns
module dfrs_jump_band (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [dfrs_pkg::FREQ_W-1:0] req_i,
    input wire logic [dfrs_pkg::JUMPS-1:0][dfrs_pkg::JUMP_W-1:0] jump_hz_i,
    input wire logic [dfrs_pkg::BAND_W-1:0] width_i,
    output logic [dfrs_pkg::FREQ_W-1:0] target_o
);
    logic [13:0] blo [dfrs_pkg::JUMPS];
    logic [13:0] bhi [dfrs_pkg::JUMPS];
    logic [dfrs_pkg::JUMPS-1:0] en;
    logic [13:0] lo;
    logic [13:0] hi;
    logic hit;
    logic [13:0] next_target;

    function automatic logic [13:0] to_cent(input logic [6:0] hz);
        to_cent = 14'(14'(hz) * dfrs_pkg::HZ_TO_CENT);
    endfunction

    // band bounds, merging and hold decision
    always_comb begin
        lo = 14'h0000;
        hi = 14'h0000;
        hit = 1'b0;
        for (int i = 0; i < dfrs_pkg::JUMPS; i++) begin
            logic [6:0] j;
            j = (jump_hz_i[i] > dfrs_pkg::JUMP_MAX) ? dfrs_pkg::JUMP_MAX : jump_hz_i[i];
            en[i] = (j != 7'h00);
            blo[i] = (j > 7'(width_i)) ? to_cent(j - 7'(width_i)) : 14'h0000;
            bhi[i] = 14'((14'(j) + 14'(width_i)) * dfrs_pkg::HZ_TO_CENT);
        end
        for (int i = 0; i < dfrs_pkg::JUMPS; i++) begin
            if (!hit && en[i] && req_i > blo[i] && req_i < bhi[i]) begin
                lo = blo[i];
                hi = bhi[i];
                hit = 1'b1;
            end
        end
        // two passes reach every chain of three touching bands
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < dfrs_pkg::JUMPS; i++) begin
                if (hit && en[i] && blo[i] <= hi && bhi[i] >= lo) begin
                    lo = (blo[i] < lo) ? blo[i] : lo;
                    hi = (bhi[i] > hi) ? bhi[i] : hi;
                end
            end
        end
        if (hit && req_i > target_o) begin
            next_target = lo;
        end else if (hit) begin
            next_target = hi;
        end else begin
            next_target = req_i;
        end
    end

    // target register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            target_o <= 14'h0000;
        end else begin
            target_o <= next_target;
        end
    end

    property p_hold_lower;
        @(posedge clk_i) disable iff (!rst_b_i)
        (hit && req_i > target_o) |=> (target_o == $past(lo));
    endproperty
    a_hold_lower: assert property (p_hold_lower) else $error("band not held low");

    property p_hold_upper;
        @(posedge clk_i) disable iff (!rst_b_i)
        (hit && req_i < target_o) |=> (target_o == $past(hi));
    endproperty
    a_hold_upper: assert property (p_hold_upper) else $error("band not held high");

    property p_disabled_pass;
        @(posedge clk_i) disable iff (!rst_b_i)
        (jump_hz_i == '0) |=> (target_o == $past(req_i));
    endproperty
    a_disabled_pass: assert property (p_disabled_pass) else $error("zero jump acted");
endmodule // dfrs_jump_band

// *** src/dfrs_lowpass.sv ***
`timescale 1ns/1ns
module dfrs_lowpass #(
    parameter int W = 12
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic tick_i,
    input wire logic [dfrs_pkg::TAU_W-1:0] tau_i,
    input wire logic [W-1:0] x_i,
    output logic [W-1:0] y_o
);
    // eight fraction bits keep small steps from stalling the approach
    logic [W+7:0] acc;
    logic [W+7:0] next_acc;
    logic signed [W+9:0] diff;

    // first order step: acc moves by (x - acc) / tau each tick
    always_comb begin
        diff = $signed({2'b00, x_i, 8'h00}) - $signed({2'b00, acc});
        if (tau_i == '0) begin
            next_acc = {x_i, 8'h00};
        end else if (tick_i) begin
            next_acc = (W+8)'($signed({2'b00, acc}) + diff / $signed({1'b0, tau_i}));
        end else begin
            next_acc = acc;
        end
    end

    // filter state
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acc <= '0;
            y_o <= '0;
        end else begin
            acc <= next_acc;
            y_o <= next_acc[W+7:8];
        end
    end

    property p_no_filter;
        @(posedge clk_i) disable iff (!rst_b_i)
        (tau_i == '0) |=> (y_o == $past(x_i));
    endproperty
    a_no_filter: assert property (p_no_filter) else $error("zero time constant lags");
endmodule // dfrs_lowpass

// *** src/dfrs_top.sv ***
// Notes on behaviour
// - zero hertz jump point is disabled
// - three jump points, 0 to 120 Hz
// - accelerating into band holds lower bound
// - above band, target follows request
// - decelerating mirrors: hold upper bound
// - touching bands merge into one
// - four selects choose presets 1 to 15
// - unassigned select input reads as off
// - presets 0.00 to 120.00 Hz, 0.01 steps
// - modes: once, repeat, once then hold
// - seven stages in ascending order
// - stage time to 6000 s, direction
// - stage picks one of four ramp sets
// - zero time stage is skipped
// - stage n uses preset n
// - forward run resumes where stopped
// - stop then reset returns to stage one
// - reverse commands ignored in pattern operation
// - cycle end stops with ramp set one
// - analog bias -100..100 %, gain 0..200 %
// - one low-pass time constant, 0 to 5 s
// - both analog inputs share that filter
`timescale 1ns/1ns
module dfrs_top #(
    parameter int TICK_CYCLES = dfrs_pkg::TICK_CYCLES
) (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic SPEED_SELECT_BIT0_I,
    input wire logic SPEED_SELECT_BIT1_I,
    input wire logic SPEED_SELECT_BIT2_I,
    input wire logic SPEED_SELECT_BIT3_I,
    input wire logic [3:0] SPEED_SELECT_ASSIGNED_I,
    input wire logic FORWARD_RUN_COMMAND_I,
    input wire logic REVERSE_RUN_COMMAND_I,
    input wire logic STOP_COMMAND_I,
    input wire logic RESET_COMMAND_I,
    input wire logic PATTERN_ENABLE_I,
    input wire logic [1:0] PATTERN_MODE_SETTING_I,
    input wire logic [dfrs_pkg::STAGES-1:0][dfrs_pkg::TIME_W-1:0] STAGE_TIME_I,
    input wire logic [dfrs_pkg::STAGES-1:0] STAGE_REVERSE_I,
    input wire logic [dfrs_pkg::STAGES-1:0][1:0] STAGE_RAMP_SET_I,
    input wire logic [15:1][dfrs_pkg::FREQ_W-1:0] PRESET_FREQ_I,
    input wire logic [dfrs_pkg::JUMPS-1:0][dfrs_pkg::JUMP_W-1:0] JUMP_HZ_I,
    input wire logic [dfrs_pkg::BAND_W-1:0] JUMP_WIDTH_I,
    input wire logic [dfrs_pkg::ADC_W-1:0] ANALOG_12_I,
    input wire logic [dfrs_pkg::ADC_W-1:0] ANALOG_C1_I,
    input wire logic signed [7:0] ANALOG_BIAS_I,
    input wire logic [7:0] ANALOG_GAIN_I,
    input wire logic [dfrs_pkg::TAU_W-1:0] ANALOG_FILTER_TIME_I,
    output logic [dfrs_pkg::FREQ_W-1:0] FREQ_TARGET_O,
    output logic RUN_O,
    output logic DIRECTION_REVERSE_O,
    output logic [1:0] RAMP_SET_O,
    output logic [2:0] STAGE_O,
    output logic PATTERN_ACTIVE_O,
    output logic [dfrs_pkg::ADC_W-1:0] ANALOG_12_FILT_O,
    output logic [dfrs_pkg::ADC_W-1:0] ANALOG_C1_FILT_O
);
    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic fwd_prev;

    // both stages only register; nothing reads pin_meta but pin_sync
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
            fwd_prev <= 1'b0;
        end else begin
            pin_meta <= {RESET_COMMAND_I, STOP_COMMAND_I, REVERSE_RUN_COMMAND_I,
                FORWARD_RUN_COMMAND_I, SPEED_SELECT_BIT3_I, SPEED_SELECT_BIT2_I,
                SPEED_SELECT_BIT1_I, SPEED_SELECT_BIT0_I};
            pin_sync <= pin_meta;
            fwd_prev <= pin_sync[4];
        end
    end

    logic forward_run_command;
    logic reverse_run_command;
    logic stop_cmd;
    logic reset_cmd;
    logic fwd_rise;
    logic [3:0] preset_idx;

    assign forward_run_command = pin_sync[4];
    assign reverse_run_command = pin_sync[5];
    assign stop_cmd = pin_sync[6];
    assign reset_cmd = pin_sync[7];
    assign fwd_rise = forward_run_command && !fwd_prev;
    // binary weights 1, 2, 4, 8; unassigned terminals forced off
    assign preset_idx = pin_sync[3:0] & SPEED_SELECT_ASSIGNED_I;

    function automatic logic [13:0] clamp_freq(input logic [13:0] f);
        clamp_freq = (f > dfrs_pkg::FREQ_MAX) ? dfrs_pkg::FREQ_MAX : f;
    endfunction

    // ****************************************************************
    // 10 ms time base
    // ****************************************************************
    logic [dfrs_pkg::TICK_W-1:0] tick_cnt;
    logic [dfrs_pkg::TICK_W-1:0] next_tick_cnt;
    logic tick;

    // free running divider shared by sequencer and filters
    always_comb begin
        tick = (tick_cnt == dfrs_pkg::TICK_W'(TICK_CYCLES - 1));
        next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= next_tick_cnt;
        end
    end

    // ****************************************************************
    // pattern sequencer
    // ****************************************************************
    dfrs_pkg::dfrs_seq_t seq_state;
    dfrs_pkg::dfrs_seq_t next_seq_state;
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic [dfrs_pkg::TIME_W-1:0] elapsed;
    logic [dfrs_pkg::TIME_W-1:0] next_elapsed;
    logic [dfrs_pkg::TIME_W-1:0] cur_time;
    logic advance;

    // stage position and elapsed time survive a stop in SEQ_RUN so a new run resumes
    always_comb begin
        next_seq_state = seq_state;
        next_stage = stage;
        next_elapsed = elapsed;
        cur_time = STAGE_TIME_I[stage];
        advance = 1'b0;
        case (seq_state)
            dfrs_pkg::SEQ_IDLE: begin
                if (reset_cmd) begin
                    next_stage = dfrs_pkg::STAGE_FIRST;
                    next_elapsed = '0;
                end else if (PATTERN_ENABLE_I && fwd_rise && !stop_cmd) begin
                    next_seq_state = dfrs_pkg::SEQ_RUN;
                end
            end
            dfrs_pkg::SEQ_RUN: begin
                if (stop_cmd || !PATTERN_ENABLE_I) begin
                    next_seq_state = dfrs_pkg::SEQ_IDLE;
                end else if (cur_time == '0) begin
                    advance = 1'b1;
                end else if (tick) begin
                    next_elapsed = elapsed + 1'b1;
                    advance = (next_elapsed >= cur_time);
                end
                if (advance) begin
                    next_elapsed = '0;
                    if (stage != dfrs_pkg::STAGE_LAST) begin
                        next_stage = stage + 1'b1;
                    end else begin
                        next_stage = dfrs_pkg::STAGE_FIRST;
                        case (PATTERN_MODE_SETTING_I)
                            dfrs_pkg::MODE_REPEAT: next_seq_state = dfrs_pkg::SEQ_RUN;
                            dfrs_pkg::MODE_HOLD_LAST: begin
                                next_stage = dfrs_pkg::STAGE_LAST;
                                next_seq_state = dfrs_pkg::SEQ_HOLD;
                            end
                            default: next_seq_state = dfrs_pkg::SEQ_IDLE;
                        endcase
                    end
                end
            end
            dfrs_pkg::SEQ_HOLD: begin
                // the cycle is over, so a stop here restarts from stage one
                if (stop_cmd || !PATTERN_ENABLE_I) begin
                    next_seq_state = dfrs_pkg::SEQ_IDLE;
                    next_stage = dfrs_pkg::STAGE_FIRST;
                end
            end
            default: begin
                next_seq_state = dfrs_pkg::SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            seq_state <= dfrs_pkg::SEQ_IDLE;
            stage <= dfrs_pkg::STAGE_FIRST;
            elapsed <= '0;
        end else begin
            seq_state <= next_seq_state;
            stage <= next_stage;
            elapsed <= next_elapsed;
        end
    end

    // ****************************************************************
    // analog reference scaling
    // ****************************************************************
    logic [19:0] gain_part;
    logic signed [21:0] bias_part;
    logic signed [21:0] ana_sum;
    logic [11:0] ana_level;
    logic [13:0] ana_freq;

    // gain in percent of reading, bias in percent of full scale
    always_comb begin
        gain_part = 20'((20'(ANALOG_12_FILT_O) * 20'(ANALOG_GAIN_I)) / 20'h00064);
        bias_part = (22'(ANALOG_BIAS_I) * 22'sh000FFF) / 22'sh000064;
        ana_sum = $signed({2'b00, gain_part}) + bias_part;
        if (ana_sum < 0) begin
            ana_level = 12'h000;
        end else if (ana_sum > $signed({10'h000, dfrs_pkg::ADC_FULL})) begin
            ana_level = dfrs_pkg::ADC_FULL;
        end else begin
            ana_level = ana_sum[11:0];
        end
        // full scale maps just under 120.00 Hz; a shift avoids a divider
        ana_freq = 14'((26'(ana_level) * 26'(dfrs_pkg::FREQ_MAX)) >> 12);
    end

    // ****************************************************************
    // request selection and outputs
    // ****************************************************************
    logic [13:0] request;
    logic [13:0] next_request;
    logic next_run;
    logic next_reverse;
    logic [1:0] next_ramp;
    logic pat_on;

    // pattern owns frequency, direction and ramps while active
    always_comb begin
        pat_on = (seq_state != dfrs_pkg::SEQ_IDLE);
        if (pat_on) begin
            next_request = clamp_freq(PRESET_FREQ_I[4'(stage) + 4'h1]);
            next_run = 1'b1;
            next_reverse = STAGE_REVERSE_I[stage];
            next_ramp = STAGE_RAMP_SET_I[stage];
        end else if (PATTERN_ENABLE_I) begin
            // stopped pattern decelerates on the first ramp set
            next_request = 14'h0000;
            next_run = 1'b0;
            next_reverse = DIRECTION_REVERSE_O;
            next_ramp = dfrs_pkg::RAMP_SET_1;
        end else begin
            if (preset_idx != 4'h0) begin
                next_request = clamp_freq(PRESET_FREQ_I[preset_idx]);
            end else begin
                next_request = ana_freq;
            end
            next_run = (forward_run_command || reverse_run_command) && !stop_cmd;
            next_reverse = reverse_run_command && !forward_run_command;
            next_ramp = dfrs_pkg::RAMP_SET_1;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            request <= 14'h0000;
            RUN_O <= 1'b0;
            DIRECTION_REVERSE_O <= 1'b0;
            RAMP_SET_O <= dfrs_pkg::RAMP_SET_1;
            STAGE_O <= dfrs_pkg::STAGE_FIRST;
            PATTERN_ACTIVE_O <= 1'b0;
        end else begin
            request <= next_request;
            RUN_O <= next_run;
            DIRECTION_REVERSE_O <= next_reverse;
            RAMP_SET_O <= next_ramp;
            STAGE_O <= stage;
            PATTERN_ACTIVE_O <= pat_on;
        end
    end

    // ****************************************************************
    // jump bands and filters
    // ****************************************************************
    dfrs_jump_band u_jump (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .req_i(request),
        .jump_hz_i(JUMP_HZ_I),
        .width_i(JUMP_WIDTH_I),
        .target_o(FREQ_TARGET_O)
    );

    // one time constant feeds both inputs
    dfrs_lowpass #(.W(dfrs_pkg::ADC_W)) u_filt_12 (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .tick_i(tick),
        .tau_i(ANALOG_FILTER_TIME_I),
        .x_i(ANALOG_12_I),
        .y_o(ANALOG_12_FILT_O)
    );

    dfrs_lowpass #(.W(dfrs_pkg::ADC_W)) u_filt_c1 (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .tick_i(tick),
        .tau_i(ANALOG_FILTER_TIME_I),
        .x_i(ANALOG_C1_I),
        .y_o(ANALOG_C1_FILT_O)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_skip_zero;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (seq_state == dfrs_pkg::SEQ_RUN && !stop_cmd && PATTERN_ENABLE_I && cur_time == '0)
            |=> (elapsed == '0 && (stage != $past(stage) || seq_state != dfrs_pkg::SEQ_RUN));
    endproperty
    a_skip_zero: assert property (p_skip_zero) else $error("zero stage not skipped");

    property p_resume;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (seq_state == dfrs_pkg::SEQ_IDLE && !reset_cmd)
            |=> (stage == $past(stage) && elapsed == $past(elapsed));
    endproperty
    a_resume: assert property (p_resume) else $error("stopped position lost");

    property p_reset_stage;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (seq_state == dfrs_pkg::SEQ_IDLE && reset_cmd) |=> (stage == dfrs_pkg::STAGE_FIRST);
    endproperty
    a_reset_stage: assert property (p_reset_stage) else $error("reset kept stage");

    property p_stage_dir;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (seq_state == dfrs_pkg::SEQ_RUN)
            |=> (DIRECTION_REVERSE_O == $past(STAGE_REVERSE_I[stage]) && RUN_O);
    endproperty
    a_stage_dir: assert property (p_stage_dir) else $error("direction not from stage");

    property p_end_ramp;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (seq_state == dfrs_pkg::SEQ_IDLE && PATTERN_ENABLE_I)
            |=> (RAMP_SET_O == dfrs_pkg::RAMP_SET_1 && !RUN_O);
    endproperty
    a_end_ramp: assert property (p_end_ramp) else $error("stop not on ramp set one");
endmodule // dfrs_top

// *** tb/dfrs_operator_model.sv ***
`timescale 1ns/1ns
// ****************************************************************
// keypad and terminal commands, held long enough for the pin synchronisers
// ****************************************************************
module dfrs_operator_model (
    input wire logic clk_i,
    output logic fwd_o,
    output logic rev_o,
    output logic stop_o,
    output logic reset_cmd_o
);
    // all commands idle at time zero
    initial begin
        fwd_o = 1'b0;
        rev_o = 1'b0;
        stop_o = 1'b0;
        reset_cmd_o = 1'b0;
    end
    // 0 forward, 1 stop, 2 reset; a short pulse would vanish in the 2FF pins
    task automatic press(input int which);
        @(negedge clk_i);
        case (which)
            0: fwd_o = 1'b1;
            1: stop_o = 1'b1;
            default: reset_cmd_o = 1'b1;
        endcase
        repeat (4) @(negedge clk_i);
        fwd_o = 1'b0;
        stop_o = 1'b0;
        reset_cmd_o = 1'b0;
    endtask
    // reverse is a plain level that the pattern run must disregard
    task automatic hold_rev(input logic v);
        @(negedge clk_i);
        rev_o = v;
    endtask
endmodule // dfrs_operator_model

// *** tb/test_drive_frequency_reference_sequencer.sv ***
`timescale 1ns/1ns
module test_drive_frequency_reference_sequencer;
    // ****************************************************************
    // stimulus and checks
    // ****************************************************************
    logic CLK_I = 1'b0;
    logic RST_B_I = 1'b0;
    logic SPEED_SELECT_BIT0_I, SPEED_SELECT_BIT1_I, SPEED_SELECT_BIT2_I, SPEED_SELECT_BIT3_I;
    logic [3:0] SPEED_SELECT_ASSIGNED_I = 4'hF;
    logic FORWARD_RUN_COMMAND_I, REVERSE_RUN_COMMAND_I, STOP_COMMAND_I, RESET_COMMAND_I;
    logic PATTERN_ENABLE_I = 1'b0;
    logic [1:0] PATTERN_MODE_SETTING_I = 2'h0;
    logic [6:0][19:0] STAGE_TIME_I = '0;
    logic [6:0] STAGE_REVERSE_I = 7'h00;
    logic [6:0][1:0] STAGE_RAMP_SET_I = '0;
    logic [15:1][13:0] PRESET_FREQ_I = '0;
    logic [2:0][6:0] JUMP_HZ_I = '0;
    logic [4:0] JUMP_WIDTH_I = 5'h05;
    logic [11:0] ANALOG_12_I = 12'h000, ANALOG_C1_I = 12'h000;
    logic signed [7:0] ANALOG_BIAS_I = 8'sh00;
    logic [7:0] ANALOG_GAIN_I = 8'h64;
    logic [8:0] ANALOG_FILTER_TIME_I = 9'h000;
    logic [13:0] FREQ_TARGET_O;
    logic RUN_O, DIRECTION_REVERSE_O, PATTERN_ACTIVE_O;
    logic [1:0] RAMP_SET_O;
    logic [2:0] STAGE_O;
    logic [11:0] ANALOG_12_FILT_O, ANALOG_C1_FILT_O;
    logic [6:0] seen = 7'h00;
    int err_count = 0;
    int tests_run = 0;
    int seed;
    logic [3:0] r;
    logic [3:0] sel_seq [6] = '{4'h1, 4'h2, 4'h3, 4'h2, 4'h1, 4'h3};
    int exp_seq [6] = '{10, 50, 60, 50, 10, 50};
    int exp_k [6] = '{0, -1, 0, 1, 0, -1};
    always #50 CLK_I = ~CLK_I;
    assign {SPEED_SELECT_BIT3_I, SPEED_SELECT_BIT2_I, SPEED_SELECT_BIT1_I, SPEED_SELECT_BIT0_I} = r;
    logic [2:0] stg_q;
    // a stage counts once it stands two clocks; a skipped one shows for one
    always @(posedge CLK_I) begin
        stg_q <= STAGE_O;
        if (PATTERN_ACTIVE_O === 1'b1 && STAGE_O === stg_q) seen[STAGE_O] <= 1'b1;
    end
    dfrs_top #(.TICK_CYCLES(10)) dfrs_top_i (.CLK_I, .RST_B_I, .SPEED_SELECT_BIT0_I,
        .SPEED_SELECT_BIT1_I, .SPEED_SELECT_BIT2_I, .SPEED_SELECT_BIT3_I, .SPEED_SELECT_ASSIGNED_I,
        .FORWARD_RUN_COMMAND_I, .REVERSE_RUN_COMMAND_I, .STOP_COMMAND_I, .RESET_COMMAND_I,
        .PATTERN_ENABLE_I, .PATTERN_MODE_SETTING_I, .STAGE_TIME_I, .STAGE_REVERSE_I,
        .STAGE_RAMP_SET_I, .PRESET_FREQ_I, .JUMP_HZ_I, .JUMP_WIDTH_I, .ANALOG_12_I, .ANALOG_C1_I,
        .ANALOG_BIAS_I, .ANALOG_GAIN_I, .ANALOG_FILTER_TIME_I, .FREQ_TARGET_O, .RUN_O,
        .DIRECTION_REVERSE_O, .RAMP_SET_O, .STAGE_O, .PATTERN_ACTIVE_O, .ANALOG_12_FILT_O,
        .ANALOG_C1_FILT_O);
    dfrs_operator_model dfrs_operator_model_i (.clk_i(CLK_I), .fwd_o(FORWARD_RUN_COMMAND_I),
        .rev_o(REVERSE_RUN_COMMAND_I), .stop_o(STOP_COMMAND_I), .reset_cmd_o(RESET_COMMAND_I));
    // effective preset index: unassigned pins count as off
    function automatic logic [3:0] idx(input logic [3:0] pins, input logic [3:0] asg);
        return pins & asg;
    endfunction
    // expected analog reference in 0.01 Hz
    function automatic logic [15:0] ana_exp(input int x, input int g, input int b);
        int v;
        v = x * g / 100 + b * 4095 / 100;
        v = (v < 0) ? 0 : (v > 4095) ? 4095 : v;
        return 16'(v * 12000 / 4096);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // select change needs sync, request and target stages before it shows
    task automatic sel(input logic [3:0] v);
        @(negedge CLK_I);
        r = v;
        repeat (8) @(negedge CLK_I);
    endtask
    // bounded wait for a stage with the given busy level
    task automatic wait_stage(input logic [2:0] s, input logic act);
        int n;
        n = 0;
        while (!(STAGE_O === s && PATTERN_ACTIVE_O === act)) begin
            @(negedge CLK_I);
            n++;
            if (n > 3000) begin
                err_count++;
                $display("Error at %0t: stage wait timed out", $time);
                wrap_up();
            end
        end
    endtask
    initial begin
        r = 4'h0;
        seed = $urandom(32'h53ab9a90);
        for (int i = 1; i < 16; i++) PRESET_FREQ_I[i] = 14'($urandom_range(12000));
        repeat (2) @(negedge CLK_I);
        RST_B_I = 1'b1;
        // every code 1..15, then random unassigned pins
        for (int i = 1; i < 20; i++) begin
            SPEED_SELECT_ASSIGNED_I = (i < 16) ? 4'hF : (4'($urandom) | 4'h1);
            sel((i < 16) ? 4'(i) : (4'($urandom) | 4'h1));
            chk(FREQ_TARGET_O, PRESET_FREQ_I[idx(r, SPEED_SELECT_ASSIGNED_I)]);
        end
        // band 50 Hz +/- w, later merged with 60 Hz +/- w; w of 5..9 touches or overlaps
        SPEED_SELECT_ASSIGNED_I = 4'hF;
        JUMP_WIDTH_I = 5'($urandom_range(9, 5));
        PRESET_FREQ_I[1] = 14'h03E8;
        PRESET_FREQ_I[2] = 14'h1388;
        PRESET_FREQ_I[3] = 14'h1770;
        JUMP_HZ_I[0] = 7'h32;
        for (int i = 0; i < 6; i++) begin
            if (i == 5) JUMP_HZ_I[1] = 7'h3C;
            sel(sel_seq[i]);
            chk(FREQ_TARGET_O, 16'((exp_seq[i] + exp_k[i] * int'(JUMP_WIDTH_I)) * 100));
        end
        // unfiltered analog path on both inputs, then the scaled reference with bands off
        JUMP_HZ_I = '0;
        ANALOG_12_I = 12'($urandom);
        ANALOG_C1_I = 12'($urandom);
        ANALOG_GAIN_I = 8'($urandom_range(200));
        ANALOG_BIAS_I = 8'(int'($urandom_range(200)) - 100);
        sel(4'h0);
        chk(ANALOG_12_FILT_O, ANALOG_12_I);
        chk(ANALOG_C1_FILT_O, ANALOG_C1_I);
        chk(FREQ_TARGET_O, ana_exp(ANALOG_12_I, ANALOG_GAIN_I, ANALOG_BIAS_I));
        // settled inputs must not drift under a nonzero time constant
        ANALOG_FILTER_TIME_I = 9'($urandom_range(500, 1));
        // one pattern cycle, stage 2 skipped, reverse held high throughout
        PATTERN_ENABLE_I = 1'b1;
        STAGE_REVERSE_I = 7'($urandom);
        STAGE_RAMP_SET_I = 14'($urandom);
        for (int s = 0; s < 7; s++)
            STAGE_TIME_I[s] = (s == 1) ? 20'h00000 : 20'($urandom_range(4, 2));
        dfrs_operator_model_i.hold_rev(1'b1);
        dfrs_operator_model_i.press(0);
        for (int s = 0; s < 7; s++) begin
            if (s == 1) continue;
            wait_stage(3'(s), 1'b1);
            repeat (3) @(negedge CLK_I);
            chk(DIRECTION_REVERSE_O, STAGE_REVERSE_I[s]);
            chk(RAMP_SET_O, STAGE_RAMP_SET_I[s]);
            chk(FREQ_TARGET_O, PRESET_FREQ_I[s + 1]);
        end
        wait_stage(3'h0, 1'b0);
        chk(seen, 7'h7D);
        chk({RUN_O, RAMP_SET_O}, 3'h0);
        // once then hold last stage
        PATTERN_MODE_SETTING_I = 2'h2;
        dfrs_operator_model_i.press(0);
        wait_stage(3'h6, 1'b1);
        repeat (100) @(negedge CLK_I);
        chk({RUN_O, STAGE_O}, 4'hE);
        dfrs_operator_model_i.press(1);
        wait_stage(3'h0, 1'b0);
        // repeat mode, stop, resume, then stop and reset
        PATTERN_MODE_SETTING_I = 2'h1;
        dfrs_operator_model_i.press(0);
        wait_stage(3'h6, 1'b1);
        wait_stage(3'h0, 1'b1);
        wait_stage(3'h3, 1'b1);
        dfrs_operator_model_i.press(1);
        repeat (50) @(negedge CLK_I);
        chk({RUN_O, STAGE_O}, 4'h3);
        dfrs_operator_model_i.press(0);
        repeat (4) @(negedge CLK_I);
        chk({RUN_O, STAGE_O}, 4'hB);
        dfrs_operator_model_i.press(1);
        dfrs_operator_model_i.press(2);
        repeat (6) @(negedge CLK_I);
        chk({RUN_O, STAGE_O}, 4'h0);
        chk(ANALOG_12_FILT_O, ANALOG_12_I);
        chk(ANALOG_C1_FILT_O, ANALOG_C1_I);
        wrap_up();
    end
endmodule // test_drive_frequency_reference_sequencer
